// *** rtl/vc_port_arb_regs.vh ***
/*
 * register offsets, field positions and port-type values for the
 * virtual-channel arbitration status/capability block.
 * assumes inclusion by a module that decodes APB byte addresses.
 */
`ifndef VC_PORT_ARB_REGS_VH
`define VC_PORT_ARB_REGS_VH

// printed offsets are register indices; byte address is index times four
`define PVS_INDEX 12'h20E
`define VRC_INDEX 12'h210
`define SEL_INDEX 12'h214
`define PVS_ADDR 14'h0838
`define VRC_ADDR 14'h0840
`define SEL_ADDR 14'h0850

`define COH_BIT 0
`define CAP_LSB 0
`define CAP_MSB 7
`define ADVSW_BIT 14
`define SNP_BIT 15
`define MTS_LSB 16
`define MTS_MSB 22
`define OFF_LSB 24
`define OFF_MSB 31
`define ASEL_LSB 17
`define ASEL_MSB 19
`define ALOAD_BIT 16

`define CAP_UP 8'h03
`define CAP_DN 8'h01
`define OFF_UP 8'h02
`define OFF_DN 8'h00
`define PVS_RESET 16'h0000
`define SEL_RESET 3'h0

`endif

// *** rtl/arb_select_store.v ***
/*
 * holds the port arbitration select and raises a one-cycle load pulse.
 * assumes writes arrive already qualified by the APB slave.
 */
`timescale 1ns/10ps
`default_nettype none
`include "vc_port_arb_regs.vh"
module arb_select_store (
    input wire pclk,
    input wire presetn,
    input wire wr_en,
    input wire [7:0] cap,
    input wire [2:0] wr_sel,
    input wire wr_load,
    output reg [2:0] sel,
    output reg load_pulse
);
    // a select whose capability bit is clear is dropped, keeping the old scheme
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel <= `SEL_RESET;
            load_pulse <= 1'b0;
        end else begin
            load_pulse <= wr_en & wr_load;
            if (wr_en && cap[wr_sel]) begin
                sel <= wr_sel;
            end
        end
    end
endmodule
`default_nettype wire

// *** rtl/vc_port_arbitration_caps.v ***
/*
 * APB slave for the port VC status and VC resource 0 capability words,
 * plus a small select/load word feeding the port arbitration logic.
 * assumes is_upstream is a static strap from the same clock domain.
 */
// The APB slave port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "vc_port_arb_regs.vh"
module vc_port_arbitration_caps (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [13:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output wire pready,
    output reg [31:0] prdata,
    output reg pslverr,
    input wire is_upstream,
    output wire [2:0] port_arb_select,
    output wire port_arb_load
);
    reg strap_up;
    reg strap_taken;
    wire [7:0] port_arb_capability;
    wire [7:0] port_arb_table_offset;
    wire [31:0] cap_word;
    wire [15:0] status_word;
    wire access;
    wire sel_write;
    reg [31:0] next_rdata;
    reg next_err;

    // strap caught once after reset release, never under the async reset
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_up <= 1'b0;
            strap_taken <= 1'b0;
        end else if (!strap_taken) begin
            strap_up <= is_upstream;
            strap_taken <= 1'b1;
        end
    end

    assign port_arb_capability = strap_up ? `CAP_UP : `CAP_DN;
    assign port_arb_table_offset = strap_up ? `OFF_UP : `OFF_DN;

    // one bit per scheme, fields packed at their positions
    assign cap_word = {port_arb_table_offset,
                       1'b0,
                       7'h00,
                       1'b0,
                       1'b0,
                       6'h00,
                       port_arb_capability};
    assign status_word = `PVS_RESET;

    assign pready = 1'b1;
    assign access = psel & penable;
    // writes to the two read-only words fall through the decode and do nothing
    assign sel_write = access & pwrite & (paddr == `SEL_ADDR) & pstrb[2];

    always @* begin
        next_rdata = 32'h00000000;
        next_err = 1'b0;
        if (paddr[1:0] != 2'b00) begin
            next_err = 1'b1;
        end else if (paddr == `PVS_ADDR) begin
            next_rdata = {16'h0000, status_word};
        end else if (paddr == `VRC_ADDR) begin
            next_rdata = cap_word;
        end else if (paddr == `SEL_ADDR) begin
            next_rdata = {12'h000, port_arb_select, 1'b0, 16'h0000};
        end else begin
            next_err = 1'b1;
        end
    end

    // read data registered in the setup cycle so it is steady during access
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            prdata <= pwrite ? 32'h00000000 : next_rdata;
            pslverr <= next_err;
        end
    end

    arb_select_store u_store (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(sel_write),
        .cap(port_arb_capability),
        .wr_sel(pwdata[`ASEL_MSB:`ASEL_LSB]),
        .wr_load(pwdata[`ALOAD_BIT] & strap_up),
        .sel(port_arb_select),
        .load_pulse(port_arb_load)
    );
endmodule
`default_nettype wire

// *** bench/vc_caps_chk.sv ***
/* assertions on the caps block ports; assumes the strap only moves in reset */
`timescale 1ns/10ps
`default_nettype none
module vc_caps_chk (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [13:0] paddr,
    input wire [31:0] prdata,
    input wire is_upstream,
    input wire [2:0] port_arb_select,
    input wire port_arb_load
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire acc = psel && penable;
    wire rd_sts = acc && !pwrite && paddr == 14'h0838;
    wire rd_cap = acc && !pwrite && paddr == 14'h0840;
    sts_zero_a: assert property (rd_sts |-> prdata == 32'h0) else $error("status");
    cap_field_a: assert property (rd_cap |-> prdata[7:0] == (is_upstream ? 8'h03 : 8'h01))
        else $error("cap");
    aps_zero_a: assert property (rd_cap |-> !prdata[14]) else $error("aps");
    snp_zero_a: assert property (rd_cap |-> !prdata[15]) else $error("snoop");
    slots_zero_a: assert property (rd_cap |-> prdata[22:16] == 7'h00) else $error("slots");
    tbl_off_a: assert property (rd_cap |-> prdata[31:24] == {6'h00, is_upstream, 1'h0})
        else $error("offset");
    rsvd_zero_a: assert property (rd_cap |-> !prdata[23] && prdata[13:6] == 8'h00)
        else $error("reserved");
    ro_write_a: assert property (acc && pwrite && paddr != 14'h0850 |=> $stable(port_arb_select))
        else $error("select moved");
    cover property (rd_cap && is_upstream);
    cover property (rd_cap && !is_upstream);
    cover property (port_arb_load);
endmodule
bind vc_port_arbitration_caps vc_caps_chk chk (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .prdata, .is_upstream, .port_arb_select, .port_arb_load);
`default_nettype wire

// *** bench/vc_port_arbitration_caps_test.sv ***
/* bench for the caps block; drives APB itself, one reset per port type */
`timescale 1ns/10ps
`default_nettype none
module vc_port_arbitration_caps_test;
    logic pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0, up = '0;
    logic [13:0] paddr = '0;
    logic [31:0] pwdata = '0, rd, prdata;
    logic pready, pslverr, port_arb_load;
    logic [2:0] port_arb_select;
    int errors = 0, comparisons = 0, ticks = 0;
    always #12.5 pclk = ~pclk;
    vc_port_arbitration_caps dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb(4'hF), .pready, .prdata, .pslverr, .is_upstream(up), .port_arb_select,
        .port_arb_load);
    task chk(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            errors++;
            $display("unexpected at %0t: saw %h want %h", $time, s, e);
        end
    endtask
    task conclude;
        if (errors == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task apb(input logic w, input logic [13:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd = prdata;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    function logic [31:0] cap_of(input logic u);
        return u ? 32'h02000003 : 32'h00000001;
    endfunction
    // generous ceiling: a pass needs well under two hundred cycles
    always @(posedge pclk) begin
        ticks++;
        if (ticks == 3000) begin
            errors++;
            conclude();
        end
    end
    initial begin
        void'($urandom(32'h056741DF));
        for (int u = 0; u < 2; u++) begin
            presetn <= 1'h0;
            up <= u[0];
            repeat (12) @(posedge pclk);
            presetn <= 1'h1;
            repeat (2) @(posedge pclk);
            apb(1'h1, 14'h0838, $urandom);
            apb(1'h1, 14'h0840, $urandom);
            apb(1'h0, 14'h0838, 32'h0);
            chk(rd, 32'h0);
            apb(1'h0, 14'h0840, 32'h0);
            chk(rd, cap_of(u[0]));
            chk({31'h0, pslverr}, 32'h0);
            apb(1'h1, 14'h0850, 32'h00010000);
            @(negedge pclk);
            chk({31'h0, port_arb_load}, {31'h0, u[0]});
            apb(1'h1, 14'h0850, 32'h00020000);
            @(negedge pclk);
            chk({29'h0, port_arb_select}, {31'h0, u[0]});
            chk({31'h0, port_arb_load}, 32'h0);
            apb(1'h0, 14'h0850, 32'h0);
            chk(rd, {14'h0, u[0], 17'h0});
        end
        conclude();
    end
endmodule
`default_nettype wire
